// File: hw/uart_thr_pkg.sv
package uart_thr_pkg;

  // Channel count and register widths
  localparam int NUM_CHAN = 4;
  localparam int LEVEL_W = 7;

  // Register addresses on the 3-bit host address
  localparam logic [2:0] ADDR_ALT_FUNC = 3'h2;
  localparam logic [2:0] ADDR_FLOW_THR = 3'h6;
  localparam logic [2:0] ADDR_TRIG_LVL = 3'h7;
  localparam logic [2:0] ADDR_READY = 3'h7;

  // Line control top bits that open the alternate function slot
  localparam logic [2:0] LCR_ALT_KEY = 3'h4;

  // Field positions
  localparam int ALT_CONCURRENT_WRITE_ENABLE_BIT = 0;
  localparam int NIB_LO_POS = 0;
  localparam int NIB_HI_POS = 4;
  localparam int LEVEL_SHIFT = 2;

  // Values after reset
  localparam logic [7:0] ALT_FUNC_RESET = 8'h00;
  localparam logic [7:0] FLOW_THR_RESET = 8'h00;
  localparam logic [7:0] TRIG_LVL_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Per-channel control bits held elsewhere in the channel
  typedef struct packed {
    logic enh_write_en;
    logic mcr_level_en;
    logic mcr_ready_en;
    logic loopback;
    logic rts_flow_en;
    logic [2:0] lcr_top;
  } chan_ctrl_s;

  // Per-channel FIFO status from the datapath
  typedef struct packed {
    logic [LEVEL_W-1:0] rx_count;
    logic [LEVEL_W-1:0] tx_space;
    logic rx_timeout;
    logic [LEVEL_W-1:0] fcr_tx_trig;
    logic [LEVEL_W-1:0] fcr_rx_trig;
  } fifo_status_s;

  // Levels handed back to the datapath
  typedef struct packed {
    logic [LEVEL_W-1:0] halt_level;
    logic [LEVEL_W-1:0] restore_level;
    logic [LEVEL_W-1:0] tx_trig;
    logic [LEVEL_W-1:0] rx_trig;
  } chan_levels_s;

endpackage

// File: hw/chan_level_regs.sv
module chan_level_regs
  import uart_thr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Write strobes and data
  input wire logic wr_flow,
  input wire logic wr_trig,
  input wire logic [7:0] wdata,
  // Channel state
  input wire logic rts_flow_en,
  input wire fifo_status_s status,
  // Results
  output logic [7:0] flow_thr_reg,
  output logic [7:0] trig_lvl_reg,
  output chan_levels_s levels,
  output logic tx_ready_reg,
  output logic rx_ready_reg,
  output logic rts_reg
);

  // Nibble times four gives a byte level of 0 to 60
  function automatic logic [LEVEL_W-1:0] nib_level(input logic [3:0] n);
    nib_level = {1'b0, n, 2'b00};
  endfunction

  logic [7:0] flow_thr_next;
  logic [7:0] trig_lvl_next;
  logic tx_ready_next;
  logic rx_ready_next;
  logic rts_next;

  // Next values for stored levels, readiness and the flow pin
  always_comb begin
    flow_thr_next = wr_flow ? wdata : flow_thr_reg;
    trig_lvl_next = wr_trig ? wdata : trig_lvl_reg;
    // Halt level in low nibble, restore level in high nibble
    levels.halt_level = nib_level(flow_thr_reg[NIB_LO_POS +: 4]);
    levels.restore_level = nib_level(flow_thr_reg[NIB_HI_POS +: 4]);
    // A zero nibble falls back to the fixed trigger
    if (trig_lvl_reg[NIB_LO_POS +: 4] == 4'h0) begin
      levels.tx_trig = status.fcr_tx_trig;
    end else begin
      levels.tx_trig = nib_level(trig_lvl_reg[NIB_LO_POS +: 4]);
    end
    if (trig_lvl_reg[NIB_HI_POS +: 4] == 4'h0) begin
      levels.rx_trig = status.fcr_rx_trig;
    end else begin
      levels.rx_trig = nib_level(trig_lvl_reg[NIB_HI_POS +: 4]);
    end
    tx_ready_next = (status.tx_space >= levels.tx_trig);
    rx_ready_next = (status.rx_count > levels.rx_trig)
                    || status.rx_timeout;
    // Hysteresis; no order check, bad levels give odd toggling
    if (!rts_flow_en) begin
      rts_next = 1'b0;
    end else if (status.rx_count >= levels.halt_level) begin
      rts_next = 1'b1;
    end else if (status.rx_count <= levels.restore_level) begin
      rts_next = 1'b0;
    end else begin
      rts_next = rts_reg;
    end
  end

  // Register everything
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flow_thr_reg <= FLOW_THR_RESET;
      trig_lvl_reg <= TRIG_LVL_RESET;
      tx_ready_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      rts_reg <= 1'b0;
    end else begin
      flow_thr_reg <= flow_thr_next;
      trig_lvl_reg <= trig_lvl_next;
      tx_ready_reg <= tx_ready_next;
      rx_ready_reg <= rx_ready_next;
      rts_reg <= rts_next;
    end
  end

endmodule

// File: hw/uart_fifo_threshold_ctrl.sv
module uart_fifo_threshold_ctrl
  import uart_thr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Host register port, strobes one cycle wide
  input wire logic [NUM_CHAN-1:0] cs_n,
  input wire logic [2:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_reg,
  output logic rvalid_reg,
  // Per-channel control bits from the rest of each channel
  input wire chan_ctrl_s [NUM_CHAN-1:0] ctrl,
  // Per-channel FIFO status from the datapath
  input wire fifo_status_s [NUM_CHAN-1:0] status,
  // Per-channel results
  output chan_levels_s [NUM_CHAN-1:0] levels,
  output logic [NUM_CHAN-1:0] rts_reg,
  output logic [NUM_CHAN-1:0] concurrent_write_enable
);

  // Channel pick for reads and for the broadcast decision.
  // Lowest selected channel wins if the host selects several.
  // Several selects at once are not a normal host cycle, so a fixed
  // priority is cheaper than flagging it and keeps reads defined.
  // Limitation: the other selected channels see no read at all.
  function automatic logic [1:0] sel_index(input logic [NUM_CHAN-1:0] c);
    sel_index = 2'd0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (!c[i]) begin
        sel_index = i[1:0];
      end
    end
  endfunction

  // Enhanced level registers open only with both enable bits
  // Both level registers share this gate, so the decode is a function
  // and the write and read paths cannot drift apart.
  function automatic logic level_open(input chan_ctrl_s c);
    level_open = c.enh_write_en && c.mcr_level_en;
  endfunction

  // Alternate slot opens only under the line control key
  // The key is checked per channel, so a broadcast only lands where
  // that channel's own line control holds the key.
  function automatic logic alt_open(input chan_ctrl_s c);
    alt_open = (c.lcr_top == LCR_ALT_KEY);
  endfunction

  // Ready register shows only when enabled and not looping back
  // Loopback hides the view, so a diagnostic run cannot mistake the
  // looped status for live traffic.
  function automatic logic ready_open(input chan_ctrl_s c);
    ready_open = c.mcr_ready_en && !c.loopback;
  endfunction

  // Decode of the host cycle; all of it is combinational from the
  // strobes, so a request acts at the edge that samples it
  logic any_sel;
  logic [1:0] sel;
  logic sel_concurrent_write_enable;
  chan_ctrl_s sel_ctrl;

  // Per-channel register copies and strobes
  // The level bytes live in the channel slices; only the alternate
  // function byte is held here because the broadcast decode reads it.
  logic [7:0] alt_func_reg [NUM_CHAN];
  logic [7:0] alt_func_next [NUM_CHAN];
  logic [7:0] flow_thr_q [NUM_CHAN];
  logic [7:0] trig_lvl_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] wr_target;
  logic [NUM_CHAN-1:0] wr_flow;
  logic [NUM_CHAN-1:0] wr_trig;
  logic [NUM_CHAN-1:0] tx_ready;
  logic [NUM_CHAN-1:0] rx_ready;
  logic [7:0] ready_vec;

  // Read port next values
  // Data and its valid flag are both registered for clean bus timing
  logic [7:0] rdata_next;
  logic rvalid_next;

  // Host cycle decode
  // The selected channel's own control bits steer the read mux;
  // writes instead look at every channel's bits separately.
  always_comb begin
    any_sel = (cs_n != '1);
    sel = sel_index(cs_n);
    sel_ctrl = ctrl[sel];
    // The selected channel's concurrent bit broadcasts the write
    sel_concurrent_write_enable = alt_func_reg[sel][ALT_CONCURRENT_WRITE_ENABLE_BIT];
  end

  // Which channels a write lands in
  // A broadcast write still has to pass each channel's own gate, so a
  // channel whose enables are off keeps its levels untouched.
  // Trade-off: the host cannot force a level into a closed channel.
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      // Each channel still applies its own gating under broadcast
      wr_target[c] = wr_stb && any_sel
                     && (sel_concurrent_write_enable || (sel == c[1:0]));
      wr_flow[c] = wr_target[c] && (addr == ADDR_FLOW_THR)
                   && level_open(ctrl[c]);
      wr_trig[c] = wr_target[c] && (addr == ADDR_TRIG_LVL)
                   && level_open(ctrl[c]);
      if (wr_target[c] && (addr == ADDR_ALT_FUNC) && alt_open(ctrl[c])) begin
        alt_func_next[c] = wdata;
      end else begin
        alt_func_next[c] = alt_func_reg[c];
      end
    end
  end

  // Alternate function registers
  // All eight bits are kept so a read returns what was written, even
  // though only the concurrent bit acts inside this block.
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (reset) begin
        alt_func_reg[c] <= ALT_FUNC_RESET;
      end else begin
        alt_func_reg[c] <= alt_func_next[c];
      end
    end
  end

  // Level registers, readiness and flow pin per channel
  // Each slice is identical; the loop keeps the four channels in step
  // and avoids hand-copied wiring that could swap two channels.
  // Readiness and the flow pin come back one cycle after status moves.
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      chan_level_regs u_levels (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_flow(wr_flow[g]),
        .wr_trig(wr_trig[g]),
        .wdata(wdata),
        .rts_flow_en(ctrl[g].rts_flow_en),
        .status(status[g]),
        .flow_thr_reg(flow_thr_q[g]),
        .trig_lvl_reg(trig_lvl_q[g]),
        .levels(levels[g]),
        .tx_ready_reg(tx_ready[g]),
        .rx_ready_reg(rx_ready[g]),
        .rts_reg(rts_reg[g])
      );
      // Concurrent bit exported for the other channel registers
      assign concurrent_write_enable[g] = alt_func_reg[g][ALT_CONCURRENT_WRITE_ENABLE_BIT];
    end
  endgenerate

  // Shared readiness: bit n of each nibble is channel n
  // Receive flags sit in the upper nibble, transmit flags in the lower,
  // so one read covers all four channels at once.
  always_comb begin
    ready_vec = {rx_ready, tx_ready};
  end

  // Read mux; unknown or closed slots answer idle data
  // Address seven is shared: the ready view wins while it is enabled and not looping back,
  // otherwise the trigger byte shows there if the level gate is open.
  // Every read still answers, so the host never waits on a closed slot.
  always_comb begin
    rdata_next = RDATA_IDLE;
    rvalid_next = 1'b0;
    if (rd_stb && any_sel) begin
      rvalid_next = 1'b1;
      if (addr == ADDR_READY && ready_open(sel_ctrl)) begin
        // Ready view takes the shared slot ahead of the trigger view
        rdata_next = ready_vec;
      end else if (addr == ADDR_TRIG_LVL && level_open(sel_ctrl)) begin
        rdata_next = trig_lvl_q[sel];
      end else if (addr == ADDR_FLOW_THR && level_open(sel_ctrl)) begin
        rdata_next = flow_thr_q[sel];
      end else if (addr == ADDR_ALT_FUNC && alt_open(sel_ctrl)) begin
        rdata_next = alt_func_reg[sel];
      end else begin
        rdata_next = RDATA_IDLE;
      end
    end
  end

  // Read data register; a write never touches the ready view
  // The valid flag stands for one cycle and data returns to idle after,
  // so stale bytes never linger on the read port.
  // A read and a write in one cycle are both taken.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_reg <= RDATA_IDLE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

endmodule

// File: dv/thr_asserts.sv
module thr_asserts
  import uart_thr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Host port
  input wire logic [NUM_CHAN-1:0] cs_n,
  input wire logic [2:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata_reg,
  input wire logic rvalid_reg,
  // Channel side
  input wire chan_ctrl_s [NUM_CHAN-1:0] ctrl,
  input wire fifo_status_s [NUM_CHAN-1:0] status,
  input wire chan_levels_s [NUM_CHAN-1:0] levels,
  input wire logic [NUM_CHAN-1:0] rts_reg,
  input wire logic [NUM_CHAN-1:0] concurrent_write_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic open0;
  logic [7:0] rdy_now;
  // Level registers of channel A are writable
  assign open0 = ctrl[0].enh_write_en && ctrl[0].mcr_level_en;
  // Readiness the status register should show, two cycles on
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      rdy_now[i] = status[i].tx_space >= levels[i].tx_trig;
      rdy_now[i+4] = status[i].rx_count > levels[i].rx_trig ||
        status[i].rx_timeout;
    end
  end
  // Channel A is the one served
  sequence s_wr0(a);
    wr_stb && !cs_n[0] && addr == a;
  endsequence
  sequence s_rdy0;
    rd_stb && !cs_n[0] && addr == ADDR_READY && ctrl[0].mcr_ready_en &&
      !ctrl[0].loopback;
  endsequence
  sequence s_flow0;
    s_wr0(ADDR_FLOW_THR) ##0 open0;
  endsequence
  sequence s_trig0;
    s_wr0(ADDR_TRIG_LVL) ##0 open0;
  endsequence
  AST_READY: assert property (s_rdy0 |=>
    rvalid_reg && rdata_reg == $past(rdy_now, 2)) else $error("ready");
  AST_HALT: assert property (s_flow0 |=>
    levels[0].halt_level == {1'b0, $past(wdata[3:0]), 2'b00})
    else $error("halt");
  AST_RESTORE: assert property (s_flow0 |=>
    levels[0].restore_level == {1'b0, $past(wdata[7:4]), 2'b00})
    else $error("restore");
  AST_FLOW_LOCK: assert property (wr_stb && !open0 |=>
    $stable(levels[0].halt_level)) else $error("flow lock");
  AST_TX_TRIG: assert property (s_trig0 |=>
    levels[0].tx_trig == ($past(wdata[3:0]) != 0 ?
    {1'b0, $past(wdata[3:0]), 2'b00} : status[0].fcr_tx_trig))
    else $error("tx trig");
  AST_TRIG_LOCK: assert property (wr_stb && !open0
    ##1 $stable(status[0]) |-> $stable(levels[0].rx_trig))
    else $error("trig lock");
  AST_RTS_HALT: assert property (ctrl[0].rts_flow_en &&
    status[0].rx_count >= levels[0].halt_level |=> rts_reg[0])
    else $error("rts halt");
  AST_RTS_OFF: assert property (!ctrl[0].rts_flow_en
    |=> !rts_reg[0]) else $error("rts off");
  AST_ALT: assert property (s_wr0(ADDR_ALT_FUNC) ##0
    ctrl[0].lcr_top == LCR_ALT_KEY |=> concurrent_write_enable[0] ==
    $past(wdata[0])) else $error("alt");
endmodule

// File: dv/host_bus_model.sv
module host_bus_model
  import uart_thr_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Strobes toward the device
  output logic [NUM_CHAN-1:0] cs_n,
  output logic [2:0] addr,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] wdata,
  // Answer from the device
  input wire logic [7:0] rdata_reg,
  input wire logic rvalid_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero so the release of reset sees no stray strobe
  initial begin
    cs_n = '1;
    addr = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  // One strobe cycle; bus inverted after so stale data is never reused
  task automatic access(input logic [3:0] sel, input logic [2:0] a,
      input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk) #1;
    cs_n = sel;
    addr = a;
    wdata = d;
    wr_stb = wr;
    rd_stb = !wr;
    @(posedge sys_clk) #1;
    // A missing answer reads unknown and fails any compare
    q = rvalid_reg ? rdata_reg : 8'hxx;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cs_n = '1;
    wdata = ~d;
    addr = ~a;
  endtask
endmodule

// File: dv/uart_fifo_threshold_ctrl_tb.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t: got %0h want %0h", $time, a, b); end end
module uart_fifo_threshold_ctrl_tb;
  import uart_thr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, rvalid_reg;
  logic [3:0] cs_n, rts_reg, concurrent_write_enable;
  logic [2:0] addr;
  logic wr_stb, rd_stb;
  logic [7:0] wdata, rdata_reg, q, t;
  chan_ctrl_s [3:0] ctrl;
  fifo_status_s [3:0] status;
  chan_levels_s [3:0] levels;
  int fails = 0, cmp_count = 0, seed;
  uart_fifo_threshold_ctrl dut (.*);
  host_bus_model host (.*);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Effective trigger: zero nibble falls back to the fixed level
  function automatic logic [6:0] eff(logic [3:0] n, logic [6:0] f);
    return n != 0 ? {1'b0, n, 2'b00} : f;
  endfunction
  function automatic logic [7:0] ready_exp(logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i] = status[i].tx_space >= eff(v[3:0], status[i].fcr_tx_trig);
      r[i+4] = status[i].rx_count > eff(v[7:4], status[i].fcr_rx_trig) ||
        status[i].rx_timeout;
    end
    return r;
  endfunction
  task automatic results;
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard well beyond the 88 cycles needed
  initial begin
    #(5000 * 50);
    fails++;
    results();
  end
  initial begin
    seed = 32'hac75;
    status = '0;
    ctrl = {4{8'b1100_0000}};
    reset = 1;
    repeat (12) @(posedge sys_clk);
    #1 reset = 0;
    // Halt above restore, loaded before flow control is on
    host.access(4'b1110, ADDR_FLOW_THR, 1, 8'h2c, q);
    `CHK(levels[0].halt_level, 7'd48)
    `CHK(levels[0].restore_level, 7'd8)
    ctrl[0].mcr_level_en = 0;
    host.access(4'b1110, ADDR_FLOW_THR, 1, 8'h51, q);
    host.access(4'b1110, ADDR_TRIG_LVL, 1, 8'h11, q);
    `CHK(levels[0].halt_level, 7'd48)
    `CHK(levels[0].tx_trig, status[0].fcr_tx_trig)
    ctrl[0].mcr_level_en = 1;
    ctrl[0].rts_flow_en = 1;
    // Mid level between restore and halt must hold the last state
    foreach (t[k]) begin
      status[0].rx_count = k[0] ? 7'd20 : (k[1] ? 7'd48 : 7'd8);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(rts_reg[0], k[1] ^ k[0])
    end
    // Concurrent writes turned on last
    ctrl[0].lcr_top = LCR_ALT_KEY;
    host.access(4'b0110, ADDR_ALT_FUNC, 1, 8'h01, q);
    `CHK(concurrent_write_enable, 4'b0001)
    ctrl[0].mcr_ready_en = 1;
    repeat (12) begin
      t = 8'($random(seed));
      t = t[2] ? t & 8'h0f : t; // Zero rx nibble corner
      host.access(4'b1110, ADDR_TRIG_LVL, 1, t, q);
      foreach (status[i]) status[i] = fifo_status_s'(29'($random(seed)));
      host.access(4'b1110, ADDR_READY, 0, 8'h00, q);
      `CHK(q, ready_exp(t))
      `CHK(levels[3].rx_trig, eff(t[7:4], status[3].fcr_rx_trig))
    end
    ctrl[0].loopback = 1;
    host.access(4'b1110, ADDR_READY, 0, 8'h00, q);
    `CHK(q, t)
    host.access(4'b1110, 3'h0, 0, 8'h00, q);
    `CHK(q, 8'h00)
    results();
  end
endmodule
bind uart_fifo_threshold_ctrl thr_asserts chk (.*);
